// ===== pkg/hpi_pkg.sv
/*
 Shared constants for the host pin interface: frame length, mode codes, state codes.
 Assumes a 40 MHz system clock and a host serial clock of at most 12.5 MHz.
*/
package hpi_pkg;
  localparam int FRAME_BITS = 24;
  localparam int CNT_W = 5;
  localparam logic [4:0] FRAME_LAST = 5'h17;
  localparam logic [23:0] FRAME_RST = 24'h000000;
  localparam real SCLK_MAX_MHZ = 12.5;
  localparam real CLK_MHZ = 40.0;
  localparam int SCLK_MIN_CYC = int'(CLK_MHZ / SCLK_MAX_MHZ);
  typedef enum logic [1:0] {
    HPI_IF_SPI_UART = 2'h0,
    HPI_IF_SPI_ONLY = 2'h1,
    HPI_IF_UART_BREAK = 2'h3
  } hpi_ifmode_t;
  typedef enum logic [1:0] {
    HPI_ST_IDLE = 2'h0,
    HPI_ST_SHIFT = 2'h1,
    HPI_ST_DONE = 2'h3
  } hpi_state_t;
endpackage

// ===== src/hpi_sync.sv
/*
 Two-flip-flop level synchroniser, parameterised width.
 Assumes inputs are quasi-static levels relative to clk_in.
*/
module hpi_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Data
  input wire logic [WIDTH-1:0] d_in,
  output logic [WIDTH-1:0] q_out
);
  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] q_ff;

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      meta_ff <= RST_VAL;
      q_ff <= RST_VAL;
    end
    else
    begin
      meta_ff <= d_in;
      q_ff <= meta_ff;
    end
  end

  assign q_out = q_ff;
endmodule // hpi_sync

// ===== src/hpi_shift.sv
/*
 Serial shifter in the host serial clock domain.
 Assumes the serial clock only toggles while chip select is low; the word holds after chip
 select rises until the first falling edge of the next frame, the count until its chip select fall.
*/
module hpi_shift #(
  parameter int BITS = hpi_pkg::FRAME_BITS
) (
  // Link clock and frame
  input wire logic sclk_in,
  input wire logic cs_n_in,
  input wire logic rst_in,
  // Serial data
  input wire logic sdi_in,
  output logic sdo_out,
  // Frame data
  input wire logic [BITS-1:0] rd_word_in,
  output logic [BITS-1:0] shift_out,
  output logic [hpi_pkg::CNT_W-1:0] count_out
);
  localparam logic [hpi_pkg::CNT_W-1:0] CNT_ONE = hpi_pkg::CNT_W'(1);
  logic [BITS-1:0] shift_ff;
  logic [hpi_pkg::CNT_W-1:0] cnt_ff;
  logic [BITS-1:0] rd_ff;
  logic sdo_ff;
  logic frame_tog_ff;
  logic wr_tog_ff;
  logic rd_tog_ff;
  logic wr_fresh;
  logic rd_fresh;

  // Each chip select fall opens a frame; clearing on chip select high would lose the word
  // before the system side could take it
  always_ff @(negedge cs_n_in or posedge rst_in)
  begin
    if (rst_in)
      frame_tog_ff <= 1'b0;
    else
      frame_tog_ff <= ~frame_tog_ff;
  end

  assign wr_fresh = frame_tog_ff ^ wr_tog_ff;
  assign rd_fresh = frame_tog_ff ^ rd_tog_ff;

  always_ff @(negedge sclk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      shift_ff <= hpi_pkg::FRAME_RST;
      cnt_ff <= '0;
      wr_tog_ff <= 1'b0;
    end
    else if (!cs_n_in)
    begin
      shift_ff <= {shift_ff[BITS-2:0], sdi_in};
      wr_tog_ff <= frame_tog_ff;
      if (wr_fresh)
        cnt_ff <= CNT_ONE;
      else if (cnt_ff != '1)
        cnt_ff <= cnt_ff + CNT_ONE;
    end
  end

  // Read data launched on rising edge, MSB first; the first rise of a frame loads the word
  always_ff @(posedge sclk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      rd_ff <= '0;
      sdo_ff <= 1'b0;
      rd_tog_ff <= 1'b0;
    end
    else if (!cs_n_in)
    begin
      rd_tog_ff <= frame_tog_ff;
      if (rd_fresh)
      begin
        sdo_ff <= rd_word_in[BITS-1];
        rd_ff <= {rd_word_in[BITS-2:0], 1'b0};
      end
      else
      begin
        sdo_ff <= rd_ff[BITS-1];
        rd_ff <= {rd_ff[BITS-2:0], 1'b0};
      end
    end
  end

  assign sdo_out = sdo_ff;
  assign shift_out = shift_ff;
  // A frame without any falling edge reports zero bits, so no stale word is taken again
  assign count_out = wr_fresh ? '0 : cnt_ff;
endmodule // hpi_shift

// ===== src/hpi_top.sv
/*
 Host pin interface: serial port, interrupt routing, modem direction, reset and
 reference/alarm pin steering. Assumes a 40 MHz clk_in and a host serial clock
 on its own domain; analog blocks are driven by the enable outputs.
*/
module hpi_top (
  // System clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic reset_n_in,
  // Serial port pins
  input wire logic sclk_in,
  input wire logic cs_n_in,
  input wire logic sdi_in,
  output logic sdo_out,
  output logic sdo_oe_out,
  // Configuration from the core
  input wire logic sdo_enable_in,
  input wire hpi_pkg::hpi_ifmode_t if_mode_in,
  input wire logic uart_tx_irq_sel_in,
  input wire logic aux_input_enable_in,
  input wire logic [hpi_pkg::FRAME_BITS-1:0] rd_word_in,
  // Core events
  input wire logic irq_in,
  input wire logic alarm_in,
  input wire logic carrier_valid_in,
  input wire logic uart_tx_data_in,
  // Frame to the core
  output logic [hpi_pkg::FRAME_BITS-1:0] frame_word_out,
  output logic frame_valid_out,
  // Misc pins
  input wire logic rts_in,
  input wire logic ref_sel_in,
  input wire logic alarm_polarity_or_aux_input,
  input wire logic uart_rx_pin,
  output logic uart_tx_pin,
  output logic alarm_out,
  output logic alarm_oe_out,
  output logic carrier_detect_out,
  output logic demod_en_out,
  output logic mod_en_out,
  output logic int_ref_en_out,
  output logic aux_adc_sel_out,
  output logic alarm_voltage_polarity,
  output logic power_down_out,
  output logic uart_rx_out
);
  logic [hpi_pkg::FRAME_BITS-1:0] shift_w;
  logic [hpi_pkg::CNT_W-1:0] cnt_w;
  logic sdo_w;
  logic [4:0] pins_s;
  logic [hpi_pkg::FRAME_BITS-1:0] word_hold_ff;
  logic [hpi_pkg::CNT_W-1:0] cnt_hold_ff;
  logic core_rst;
  logic cs_n_s;
  logic cs_n_d_ff;
  hpi_pkg::hpi_state_t state_ff;
  hpi_pkg::hpi_state_t nxt_state;
  logic [hpi_pkg::FRAME_BITS-1:0] frame_word_ff;
  logic frame_valid_ff;
  logic demod_ff;
  logic mod_ff;
  logic ref_ff;
  logic aux_ff;
  logic pol_ff;
  logic pd_ff;
  logic uart_rx_ff;
  logic uart_tx_ff;
  logic alarm_ff;
  logic cd_ff;
  logic rst_n_s;

  // Link-side shifter; its word and count hold still once chip select is high
  hpi_shift #(
    .BITS(hpi_pkg::FRAME_BITS)
  ) u_shift (
    .sclk_in(sclk_in),
    .cs_n_in(cs_n_in),
    .rst_in(core_rst),
    .sdi_in(sdi_in),
    .sdo_out(sdo_w),
    .rd_word_in(rd_word_in),
    .shift_out(shift_w),
    .count_out(cnt_w)
  );

  // Reset pin: synchronised, then used as a reset for the link side too
  hpi_sync #(
    .WIDTH(1),
    .RST_VAL(1'b0)
  ) u_sync_rst (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .d_in(reset_n_in),
    .q_out(rst_n_s)
  );

  assign core_rst = rst_in | ~rst_n_s;

  hpi_sync #(
    .WIDTH(5),
    .RST_VAL(5'h11)
  ) u_sync_pins (
    .clk_in(clk_in),
    .rst_in(core_rst),
    .d_in({cs_n_in, rts_in, ref_sel_in, alarm_polarity_or_aux_input, uart_rx_pin}),
    .q_out(pins_s)
  );
  assign cs_n_s = pins_s[4];

  // Shifter words are static once chip select is high, so a single stage settles them
  always_ff @(posedge clk_in or posedge core_rst)
  begin
    if (core_rst)
    begin
      word_hold_ff <= hpi_pkg::FRAME_RST;
      cnt_hold_ff <= '0;
      cs_n_d_ff <= 1'b1;
    end
    else
    begin
      word_hold_ff <= shift_w;
      cnt_hold_ff <= cnt_w;
      cs_n_d_ff <= cs_n_s;
    end
  end

  // Frame state machine
  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      hpi_pkg::HPI_ST_IDLE:
        if (!cs_n_s)
          nxt_state = hpi_pkg::HPI_ST_SHIFT;
      hpi_pkg::HPI_ST_SHIFT:
        if (cs_n_s && cs_n_d_ff)
          nxt_state = hpi_pkg::HPI_ST_DONE;
      hpi_pkg::HPI_ST_DONE:
        nxt_state = hpi_pkg::HPI_ST_IDLE;
      default:
        nxt_state = hpi_pkg::HPI_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_in or posedge core_rst)
  begin
    if (core_rst)
      state_ff <= hpi_pkg::HPI_ST_IDLE;
    else
      state_ff <= nxt_state;
  end

  // Short or long frames are dropped; only exactly 24 bits count
  always_ff @(posedge clk_in or posedge core_rst)
  begin
    if (core_rst)
    begin
      frame_word_ff <= hpi_pkg::FRAME_RST;
      frame_valid_ff <= 1'b0;
    end
    else
    begin
      frame_valid_ff <= 1'b0;
      if (state_ff == hpi_pkg::HPI_ST_DONE && cnt_hold_ff == hpi_pkg::CNT_W'(hpi_pkg::FRAME_BITS))
      begin
        frame_word_ff <= word_hold_ff;
        frame_valid_ff <= 1'b1;
      end
    end
  end

  // Pin steering
  always_ff @(posedge clk_in or posedge core_rst)
  begin
    if (core_rst)
    begin
      demod_ff <= 1'b0;
      // Modulator side in reset, matching the synchronised request-to-send reset level
      mod_ff <= 1'b1;
      ref_ff <= 1'b0;
      aux_ff <= 1'b0;
      pol_ff <= 1'b0;
      uart_rx_ff <= 1'b1;
    end
    else
    begin
      demod_ff <= pins_s[3];
      mod_ff <= ~pins_s[3];
      ref_ff <= pins_s[2];
      aux_ff <= aux_input_enable_in;
      pol_ff <= aux_input_enable_in ? 1'b0 : pins_s[1];
      uart_rx_ff <= pins_s[0];
    end
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      pd_ff <= 1'b1;
    else
      pd_ff <= ~rst_n_s;
  end

  always_ff @(posedge clk_in or posedge core_rst)
  begin
    if (core_rst)
    begin
      uart_tx_ff <= 1'b1;
      alarm_ff <= 1'b0;
      cd_ff <= 1'b0;
    end
    else
    begin
      if (if_mode_in == hpi_pkg::HPI_IF_SPI_ONLY && uart_tx_irq_sel_in)
        uart_tx_ff <= irq_in;
      else
        uart_tx_ff <= uart_tx_data_in;
      alarm_ff <= alarm_in;
      cd_ff <= carrier_valid_in;
    end
  end

  // Data output pin: driven from the link side in serial mode, from the core in break mode
  always_comb
  begin
    if (if_mode_in == hpi_pkg::HPI_IF_UART_BREAK)
    begin
      sdo_out = irq_in;
      sdo_oe_out = sdo_enable_in && !core_rst;
    end
    else
    begin
      sdo_out = sdo_w;
      sdo_oe_out = sdo_enable_in && !cs_n_in && !core_rst;
    end
  end

  assign frame_word_out = frame_word_ff;
  assign frame_valid_out = frame_valid_ff;
  assign demod_en_out = demod_ff;
  assign mod_en_out = mod_ff;
  assign int_ref_en_out = ref_ff;
  assign aux_adc_sel_out = aux_ff;
  assign alarm_voltage_polarity = pol_ff;
  assign power_down_out = pd_ff;
  assign uart_rx_out = uart_rx_ff;
  assign uart_tx_pin = uart_tx_ff;
  assign alarm_out = 1'b0;
  assign alarm_oe_out = alarm_ff;
  assign carrier_detect_out = cd_ff;

  a_frame_valid_pulse: assert property (@(posedge clk_in) disable iff (core_rst)
    frame_valid_out |=> !frame_valid_out) else $error("frame valid longer than one cycle");
  a_frame_after_done: assert property (@(posedge clk_in) disable iff (core_rst)
    frame_valid_out |-> $past(state_ff) == hpi_pkg::HPI_ST_DONE) else $error("frame without done");
  a_modem_dir_excl: assert property (@(posedge clk_in) disable iff (core_rst)
    demod_en_out != mod_en_out) else $error("modulator and demodulator both on or off");
  a_modem_dir_follow: assert property (@(posedge clk_in) disable iff (core_rst)
    $rose(pins_s[3]) |=> demod_en_out) else $error("demodulator not enabled");
  a_ref_follow: assert property (@(posedge clk_in) disable iff (core_rst)
    int_ref_en_out == $past(pins_s[2])) else $error("reference enable wrong");
  a_aux_pol_gate: assert property (@(posedge clk_in) disable iff (core_rst)
    aux_adc_sel_out |-> !alarm_voltage_polarity) else $error("polarity driven in aux mode");
  a_sdo_float_cs: assert property (@(posedge clk_in) disable iff (core_rst)
    (cs_n_in && if_mode_in != hpi_pkg::HPI_IF_UART_BREAK) |-> !sdo_oe_out) else $error("data out driven");
  a_sdo_needs_en: assert property (@(posedge clk_in) disable iff (core_rst)
    !sdo_enable_in |-> !sdo_oe_out) else $error("data out driven before enable");
  a_alarm_follow: assert property (@(posedge clk_in) disable iff (core_rst)
    alarm_in |=> alarm_oe_out && !alarm_out) else $error("alarm not pulled low");
  a_cd_follow: assert property (@(posedge clk_in) disable iff (core_rst)
    carrier_valid_in |=> carrier_detect_out) else $error("carrier detect missing");
  a_pd_reset: assert property (@(posedge clk_in) disable iff (rst_in)
    !rst_n_s |=> power_down_out) else $error("no power-down on reset pin");

  c_frame_done: cover property (@(posedge clk_in) disable iff (core_rst) frame_valid_out);
  c_break_irq: cover property (@(posedge clk_in) disable iff (core_rst)
    if_mode_in == hpi_pkg::HPI_IF_UART_BREAK && sdo_oe_out);
  c_tx_irq: cover property (@(posedge clk_in) disable iff (core_rst)
    if_mode_in == hpi_pkg::HPI_IF_SPI_ONLY && uart_tx_irq_sel_in);
  c_short_frame: cover property (@(posedge clk_in) disable iff (core_rst)
    state_ff == hpi_pkg::HPI_ST_DONE && cnt_hold_ff != hpi_pkg::CNT_W'(hpi_pkg::FRAME_BITS));
  c_demod_on: cover property (@(posedge clk_in) disable iff (core_rst) $rose(demod_en_out));
endmodule // hpi_top

// ===== verif/hpi_host.sv
/*
 Host serial master model: chip select, serial clock and data out, read data in.
 Assumes the bench calls xfer by hierarchy; the serial clock idles low between frames.
*/
module hpi_host (
  // Serial pins
  output logic sclk_out,
  output logic cs_n_out,
  output logic sdi_out,
  input wire logic sdo_in
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [23:0] got;
  initial
  begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    sdi_out = 1'b0;
    got = '0;
  end
  // Half period 62.5 ns gives 8 MHz, under the serial clock ceiling
  task automatic xfer(input int nbits, input logic [23:0] word);
    int i;
    got = '0;
    // Chip select stays high this long before a frame, so the bench can watch the strobe after it
    #150;
    cs_n_out = 1'b0;
    for (i = nbits - 1; i >= 0; i--)
    begin
      #62.5 sclk_out = 1'b1;
      sdi_out = word[i];
      #62.5 sclk_out = 1'b0;
      got = {got[22:0], sdo_in};
    end
    #62.5 cs_n_out = 1'b1;
    // Released data line shows the inverse, so a device that still listens sees junk
    sdi_out = ~sdi_out;
  endtask
endmodule // hpi_host

// ===== verif/host_pin_interface_test.sv
/*
 Self-checking bench for the host pin interface, scenario tasks and one verdict.
 Assumes hpi_top from src and the host model; inputs change on clk_in falls.
*/
module host_pin_interface_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_in, rst_in, reset_n_in, sdo_enable_in, uart_tx_irq_sel_in, aux_input_enable_in;
  logic irq_in, alarm_in, carrier_valid_in, uart_tx_data_in, rts_in, ref_sel_in;
  logic alarm_polarity_or_aux_input, uart_rx_pin, sclk, cs_n, sdi, sdo_wire, oe_seen;
  hpi_pkg::hpi_ifmode_t if_mode_in;
  logic [23:0] rd_word_in, frame_word_out;
  logic sdo_out, sdo_oe_out, frame_valid_out, uart_tx_pin, alarm_out, alarm_oe_out;
  logic carrier_detect_out, demod_en_out, mod_en_out, int_ref_en_out, aux_adc_sel_out;
  logic alarm_voltage_polarity, power_down_out, uart_rx_out;
  int mismatches = 0;
  int check_count = 0;
  assign sdo_wire = sdo_oe_out ? sdo_out : 1'bz;
  hpi_host host (.sclk_out(sclk), .cs_n_out(cs_n), .sdi_out(sdi), .sdo_in(sdo_wire));
  hpi_top dut (.clk_in(clk_in), .rst_in(rst_in), .reset_n_in(reset_n_in), .sclk_in(sclk),
    .cs_n_in(cs_n), .sdi_in(sdi), .sdo_out(sdo_out), .sdo_oe_out(sdo_oe_out),
    .sdo_enable_in(sdo_enable_in), .if_mode_in(if_mode_in), .uart_tx_irq_sel_in(uart_tx_irq_sel_in),
    .aux_input_enable_in(aux_input_enable_in), .rd_word_in(rd_word_in), .irq_in(irq_in),
    .alarm_in(alarm_in), .carrier_valid_in(carrier_valid_in), .uart_tx_data_in(uart_tx_data_in),
    .frame_word_out(frame_word_out), .frame_valid_out(frame_valid_out), .rts_in(rts_in),
    .ref_sel_in(ref_sel_in), .alarm_polarity_or_aux_input(alarm_polarity_or_aux_input),
    .uart_rx_pin(uart_rx_pin), .uart_tx_pin(uart_tx_pin), .alarm_out(alarm_out),
    .alarm_oe_out(alarm_oe_out), .carrier_detect_out(carrier_detect_out),
    .demod_en_out(demod_en_out), .mod_en_out(mod_en_out), .int_ref_en_out(int_ref_en_out),
    .aux_adc_sel_out(aux_adc_sel_out), .alarm_voltage_polarity(alarm_voltage_polarity),
    .power_down_out(power_down_out), .uart_rx_out(uart_rx_out));
  initial
  begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end
  always @(posedge sdo_oe_out) oe_seen = 1'b1;
  task automatic final_report();
    if (mismatches == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) @(negedge clk_in);
  endtask
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    check_count++;
    if (got !== exp)
    begin
      $display("CHECK FAILED t=%0t got %h expected %h", $time, got, exp);
      mismatches++;
    end
  endtask
  // Bounded wait for the one-cycle frame strobe
  task automatic wait_valid(output logic seen);
    int i;
    seen = 1'b0;
    for (i = 0; i < 12 && !seen; i++)
    begin
      @(negedge clk_in);
      seen = (frame_valid_out === 1'b1);
    end
  endtask
  task automatic t_frames();
    logic seen;
    sdo_enable_in = 1'b1;
    rd_word_in = 24'h3c5a96;
    host.xfer(24, 24'ha5c3f1);
    wait_valid(seen);
    chk(seen, 1'b1);
    if (!seen)
      final_report();
    chk(frame_word_out, 24'ha5c3f1);
    chk(host.got, 24'h3c5a96);
    chk(sdo_oe_out, 1'b0);
    host.xfer(23, 24'h7e0f55);
    wait_valid(seen);
    chk(seen, 1'b0);
    chk(frame_word_out, 24'ha5c3f1);
    sdo_enable_in = 1'b0;
    oe_seen = 1'b0;
    host.xfer(24, 24'h0f1e2d);
    wait_valid(seen);
    chk(seen, 1'b1);
    chk(frame_word_out, 24'h0f1e2d);
    chk(oe_seen, 1'b0);
  endtask
  task automatic t_irq();
    sdo_enable_in = 1'b1;
    if_mode_in = hpi_pkg::HPI_IF_UART_BREAK;
    irq_in = 1'b1;
    step(4);
    chk({sdo_oe_out, sdo_out}, 2'h3);
    sdo_enable_in = 1'b0;
    step(2);
    chk(sdo_oe_out, 1'b0);
    sdo_enable_in = 1'b1;
    irq_in = 1'b0;
    step(4);
    chk({sdo_oe_out, sdo_out}, 2'h2);
    if_mode_in = hpi_pkg::HPI_IF_SPI_ONLY;
    uart_tx_irq_sel_in = 1'b1;
    irq_in = 1'b1;
    step(4);
    chk(uart_tx_pin, 1'b1);
    irq_in = 1'b0;
    step(4);
    chk(uart_tx_pin, 1'b0);
    if_mode_in = hpi_pkg::HPI_IF_SPI_UART;
    uart_tx_data_in = 1'b1;
    step(4);
    chk(uart_tx_pin, 1'b1);
    uart_tx_data_in = 1'b0;
    irq_in = 1'b1;
    step(4);
    chk(uart_tx_pin, 1'b0);
    irq_in = 1'b0;
    uart_tx_irq_sel_in = 1'b0;
  endtask
  task automatic t_pins();
    int i;
    for (i = 0; i < 4; i++)
    begin
      rts_in = i[0];
      carrier_valid_in = i[0];
      aux_input_enable_in = i[0];
      ref_sel_in = i[1];
      alarm_in = i[1];
      alarm_polarity_or_aux_input = i[1];
      uart_rx_pin = i[1];
      step(5);
      chk({demod_en_out, mod_en_out}, {i[0], ~i[0]});
      chk(int_ref_en_out, i[1]);
      chk({aux_adc_sel_out, alarm_voltage_polarity}, {i[0], i[1] & ~i[0]});
      chk({alarm_oe_out, alarm_out}, {i[1], 1'b0});
      chk(carrier_detect_out, i[0]);
      chk(uart_rx_out, i[1]);
    end
    uart_rx_pin = 1'b1; // Unused receive input is held high
  endtask
  task automatic t_pin_reset();
    reset_n_in = 1'b0;
    step(6);
    chk(power_down_out, 1'b1);
    chk(frame_word_out, hpi_pkg::FRAME_RST);
    reset_n_in = 1'b1;
    step(6);
    chk(power_down_out, 1'b0);
  endtask
  initial
  begin
    rst_in = 1'b1;
    reset_n_in = 1'b1;
    {sdo_enable_in, uart_tx_irq_sel_in, aux_input_enable_in, irq_in, alarm_in} = '0;
    {carrier_valid_in, uart_tx_data_in, rts_in, ref_sel_in, alarm_polarity_or_aux_input} = '0;
    uart_rx_pin = 1'b1;
    if_mode_in = hpi_pkg::HPI_IF_SPI_UART;
    rd_word_in = '0;
    oe_seen = 1'b0;
    step(2);
    chk({power_down_out, sdo_oe_out}, 2'h2);
    rst_in = 1'b0;
    step(5);
    chk({power_down_out, sdo_oe_out}, 2'h0);
    t_frames();
    t_irq();
    t_pins();
    t_pin_reset();
    final_report();
  end
  initial
  begin
    #2ms;
    mismatches++;
    final_report();
  end
endmodule // host_pin_interface_test
